/* common/alc_pkg.sv */
package alc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ALC_ADDR_LED3 = 8'h18; // led3_sink_level
  localparam logic [7:0] ALC_ADDR_LED2 = 8'h19; // led2_sink_level
  localparam logic [7:0] ALC_ADDR_LED1 = 8'h1a; // led1_sink_level
  localparam logic [7:0] ALC_ADDR_CFG1 = 8'h1b; // sensor_one_comparator_setup
  localparam logic [7:0] ALC_ADDR_CFG2 = 8'h1c; // sensor_two_comparator_setup
  localparam logic [7:0] ALC_ADDR_OTHR = 8'h1d; // office_level_threshold
  localparam logic [7:0] ALC_ADDR_OHYS = 8'h1e; // office_level_hysteresis
  localparam logic [7:0] ALC_REG_RST   = 8'h00; // Reset value of all regs
  localparam logic [7:0] ALC_UNMAPPED  = 8'h00; // Read of a hole

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ALC_CODE_W = 7;  // Sink current code
  localparam int ALC_CONV_W = 13; // Conversion value
  localparam int ALC_ACC_W  = 20; // Filter accumulator, 128 samples
  localparam int ALC_CNT_W  = 7;  // Filter sample counter
  localparam int ALC_TICK_W = 24; // Conversion interval counter
  // Office codes are 8x coarser than the conversion LSB
  localparam int ALC_OFFICE_SHIFT = 3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int ALC_CLK_KHZ     = 200000; // mclk rate
  localparam int ALC_CONV_MS     = 80;     // Conversion interval
  localparam int ALC_CONV_CYCLES = ALC_CONV_MS * ALC_CLK_KHZ;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Comparator setup byte, bit 7 down to bit 0
  typedef struct packed {
    logic [2:0] period;     // Smoothing period code
    logic       force_rd;   // One-shot conversion request
    logic       dark_out;   // Dark comparator result
    logic       office_out; // Office comparator result
    logic       dark_en;    // Dark comparator enable
    logic       office_en;  // Office comparator enable
  } alc_cmp_cfg_t;

  // Register port request from the serial interface engine
  typedef struct packed {
    logic [7:0] addr;  // Register address
    logic [7:0] wdata; // Write data
    logic       wr;    // Write strobe
    logic       rd;    // Read strobe
  } alc_reg_req_t;

  // Backlight level chosen by one sensor input
  typedef enum logic [1:0] {
    ALC_DAYLIGHT = 2'b00,
    ALC_OFFICE   = 2'b01,
    ALC_DARK     = 2'b10
  } alc_level_t;

endpackage

/* rtl/alc_compare.sv */
`timescale 1ns/1ps
module alc_compare
  import alc_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = ALC_CONV_CYCLES
) (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire alc_reg_req_t          reg_req,
  output logic [7:0]                 reg_rd_data,
  input  wire logic [ALC_CONV_W-1:0] first_light_input,
  input  wire logic [ALC_CONV_W-1:0] second_light_input,
  input  wire logic                  backlight_on,
  input  wire logic                  sinks_running,
  input  wire logic [7:0]            dark_threshold_code,
  input  wire logic [7:0]            dark_hysteresis_code,
  output logic [ALC_CODE_W-1:0]      led1_current_code,
  output logic [ALC_CODE_W-1:0]      led2_current_code,
  output logic [ALC_CODE_W-1:0]      led3_current_code,
  output alc_level_t                 level_one,
  output alc_level_t                 level_two,
  output logic [ALC_CONV_W-1:0]      conv_value_one,
  output logic [ALC_CONV_W-1:0]      conv_value_two
);
  // Checks sample on mclk and rest while reset is low
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Last sample index of a smoothing window of 2^p conversions
  function automatic logic [ALC_CNT_W-1:0] last_idx(input logic [2:0] p);
    last_idx = (7'h01 << p) - 7'h01;
  endfunction

  // Hysteresis comparator: trip below thr, release above thr+hys
  function automatic logic hyst(input logic                  cur,
                                input logic [ALC_CONV_W-1:0] val,
                                input logic [7:0]            thr,
                                input logic [7:0]            hys);
    logic [ALC_CONV_W-1:0] lo;
    logic [ALC_CONV_W-1:0] hi;
    lo = {5'h00, thr};
    hi = lo + {5'h00, hys};
    if (val < lo) begin
      hyst = 1'b1;
    end else if (val > hi) begin
      hyst = 1'b0;
    end else begin
      hyst = cur;
    end
  endfunction

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [ALC_CODE_W-1:0] led_q [3];     // LED1..3 sink codes
  logic [7:0]            othr_q;        // Office threshold code
  logic [7:0]            ohys_q;        // Office hysteresis code
  logic [2:0]            period_q [2];  // Smoothing period per input
  logic [1:0]            force_q;       // One-shot requests
  logic [1:0]            den_q;         // Dark comparator enables
  logic [1:0]            oen_q;         // Office comparator enables
  logic [1:0]            dark_q;        // Dark results
  logic [1:0]            office_q;      // Office results
  logic [7:0]            rd_q;          // Registered read data

  // Decoded strobes
  wire          wr_led3  = reg_req.wr && reg_req.addr == ALC_ADDR_LED3;
  wire          wr_led2  = reg_req.wr && reg_req.addr == ALC_ADDR_LED2;
  wire          wr_led1  = reg_req.wr && reg_req.addr == ALC_ADDR_LED1;
  wire          wr_othr  = reg_req.wr && reg_req.addr == ALC_ADDR_OTHR;
  wire          wr_ohys  = reg_req.wr && reg_req.addr == ALC_ADDR_OHYS;
  wire [1:0]    cfg_we;  // Setup register writes per input
  wire alc_cmp_cfg_t wcfg = alc_cmp_cfg_t'(reg_req.wdata);
  assign cfg_we[0] = reg_req.wr && reg_req.addr == ALC_ADDR_CFG1;
  assign cfg_we[1] = reg_req.wr && reg_req.addr == ALC_ADDR_CFG2;

  // ----------------------------------------------------------------
  // Conversion interval
  // ----------------------------------------------------------------
  logic [ALC_TICK_W-1:0] tick_cnt_q; // Counts mclk within one interval
  wire tick = tick_cnt_q == ALC_TICK_W'(CONV_CYCLES - 1);

  // Free-running interval counter
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Per-input conversion, smoothing and comparators
  // ----------------------------------------------------------------
  logic [ALC_CONV_W-1:0] sample [2];   // Live input per channel
  logic [ALC_CONV_W-1:0] conv_q [2];   // Latest result, smoothed or one-shot raw
  logic [1:0]            vld_q;        // New value in conv_q
  logic [1:0]            busy_q;       // Forced conversion in flight
  logic [1:0]            fstart;       // Forced conversion accepted
  logic [1:0]            fdrop;        // Forced request ignored
  logic [1:0]            pstep;        // Periodic sample taken
  alc_level_t            level [2];    // Chosen backlight level

  assign sample[0] = first_light_input;
  assign sample[1] = second_light_input;

  for (genvar i = 0; i < 2; i++) begin : g_ch
    logic [ALC_ACC_W-1:0] acc_q;  // Window accumulator
    logic [ALC_CNT_W-1:0] cnt_q;  // Samples in window so far
    wire  [ALC_ACC_W-1:0] acc_n = acc_q + {7'h00, sample[i]};
    wire  [ALC_CONV_W-1:0] conv_office =
      conv_q[i] >> ALC_OFFICE_SHIFT;
    wire  win_end = cnt_q == last_idx(period_q[i]);

    // accept one-shot only with sinks running, backlight off
    assign fstart[i] = force_q[i] && !busy_q[i] && sinks_running
                       && !backlight_on;
    assign fdrop[i]  = force_q[i] && !busy_q[i] && backlight_on;
    // periodic sampling while the sensor is in use
    assign pstep[i]  = tick && backlight_on && (den_q[i] || oen_q[i]);

    // Smoothing window and conversion result
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        acc_q     <= '0;
        cnt_q     <= '0;
        conv_q[i] <= '0;
        vld_q[i]  <= 1'b0;
        busy_q[i] <= 1'b0;
      end else begin
        vld_q[i] <= 1'b0;
        if (fstart[i]) begin
          // One raw conversion, window left untouched
          conv_q[i] <= sample[i];
          vld_q[i]  <= 1'b1;
          busy_q[i] <= 1'b1;
        end else if (cfg_we[i]) begin // New setup, fresh window
          acc_q     <= '0;
          cnt_q     <= '0;
        end else if (pstep[i] && win_end) begin
          conv_q[i] <= ALC_CONV_W'(acc_n >> period_q[i]);
          vld_q[i]  <= 1'b1;
          acc_q     <= '0;
          cnt_q     <= '0;
        end else if (pstep[i]) begin
          acc_q <= acc_n;
          cnt_q <= cnt_q + 1'b1;
        end
        if (vld_q[i]) begin
          busy_q[i] <= 1'b0;
        end
      end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        dark_q[i]   <= 1'b0;
        office_q[i] <= 1'b0;
      end else begin
        if (!den_q[i]) begin
          dark_q[i] <= 1'b0;
        end else if (vld_q[i]) begin
          dark_q[i] <= hyst(dark_q[i], conv_q[i], dark_threshold_code,
                            dark_hysteresis_code);
        end
        if (!oen_q[i]) begin
          office_q[i] <= 1'b0;
        end else if (vld_q[i]) begin
          // office trip, 4.3 uA scaled codes
          office_q[i] <= hyst(office_q[i], conv_office, othr_q, ohys_q);
        end
      end
    end

    assign level[i] = dark_q[i]   ? ALC_DARK   :
                      office_q[i] ? ALC_OFFICE : ALC_DAYLIGHT;
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Plain read/write registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      led_q[0] <= ALC_CODE_W'(ALC_REG_RST);
      led_q[1] <= ALC_CODE_W'(ALC_REG_RST);
      led_q[2] <= ALC_CODE_W'(ALC_REG_RST);
      othr_q   <= ALC_REG_RST;
      ohys_q   <= ALC_REG_RST;
    end else begin
      if (wr_led1) led_q[0] <= reg_req.wdata[ALC_CODE_W-1:0];
      if (wr_led2) led_q[1] <= reg_req.wdata[ALC_CODE_W-1:0];
      if (wr_led3) led_q[2] <= reg_req.wdata[ALC_CODE_W-1:0];
      if (wr_othr) othr_q   <= reg_req.wdata;
      if (wr_ohys) ohys_q   <= reg_req.wdata;
    end
  end

  // both setup registers share one field layout
  for (genvar i = 0; i < 2; i++) begin : g_cfg
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        period_q[i] <= '0;
        force_q[i]  <= 1'b0;
        den_q[i]    <= 1'b0;
        oen_q[i]    <= 1'b0;
      end else begin
        if (cfg_we[i]) begin
          period_q[i] <= wcfg.period;
          den_q[i]    <= wcfg.dark_en;
          oen_q[i]    <= wcfg.office_en;
        end
        // self-clear once results valid; a write-1 wins
        if (cfg_we[i] && wcfg.force_rd) begin
          force_q[i] <= 1'b1;
        end else if ((busy_q[i] && vld_q[i]) || fdrop[i]) begin
          force_q[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  alc_cmp_cfg_t rcfg [2]; // Setup read views
  for (genvar i = 0; i < 2; i++) begin : g_rd
    // live results in bits 3 and 2
    assign rcfg[i] = '{period: period_q[i], force_rd: force_q[i],
                       dark_out: dark_q[i], office_out: office_q[i],
                       dark_en: den_q[i], office_en: oen_q[i]};
  end

  logic [7:0] rd_mux; // Read data selected by address
  always_comb begin
    unique case (reg_req.addr)
      ALC_ADDR_LED3: rd_mux = {1'b0, led_q[2]};
      ALC_ADDR_LED2: rd_mux = {1'b0, led_q[1]};
      ALC_ADDR_LED1: rd_mux = {1'b0, led_q[0]};
      ALC_ADDR_CFG1: rd_mux = rcfg[0];
      ALC_ADDR_CFG2: rd_mux = rcfg[1];
      ALC_ADDR_OTHR: rd_mux = othr_q;
      ALC_ADDR_OHYS: rd_mux = ohys_q;
      default:       rd_mux = ALC_UNMAPPED;
    endcase
  end

  // Read data captured on the read strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= ALC_REG_RST;
    end else if (reg_req.rd) begin
      rd_q <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rd_data       = rd_q;
  // codes to the sink DACs, law applied there
  assign led1_current_code = led_q[0];
  assign led2_current_code = led_q[1];
  assign led3_current_code = led_q[2];
  assign level_one         = level[0];
  assign level_two         = level[1];
  assign conv_value_one    = conv_q[0];
  assign conv_value_two    = conv_q[1];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_chk
    wire [ALC_CONV_W-1:0] co = conv_q[i] >> ALC_OFFICE_SHIFT;
    wire [ALC_CONV_W-1:0] olim = {5'h00, othr_q} + {5'h00, ohys_q};
    wire [ALC_CONV_W-1:0] dlim = {5'h00, dark_threshold_code}
                                 + {5'h00, dark_hysteresis_code};

    force_clear_a: assert property (fstart[i] |=> vld_q[i] ##1
      (!force_q[i] || $past(cfg_we[i]))) else $error("one-shot stuck");
    force_drop_a: assert property (fdrop[i] && !cfg_we[i] |=>
      !force_q[i] && !busy_q[i]) else $error("one-shot not dropped");
    dark_prio_a: assert property (dark_q[i] |->
      level[i] == ALC_DARK) else $error("dark not prioritised");
    office_trip_a: assert property (vld_q[i] && oen_q[i] &&
      co < {5'h00, othr_q} && !$past(cfg_we[i]) |=> office_q[i])
      else $error("office trip missed");
    office_rel_a: assert property (vld_q[i] && co > olim
      |=> !office_q[i]) else $error("office release missed");
    dark_trip_a: assert property (vld_q[i] && den_q[i] &&
      conv_q[i] < {5'h00, dark_threshold_code} && !cfg_we[i]
      |=> dark_q[i]) else $error("dark trip missed");
    dark_rel_a: assert property (vld_q[i] && conv_q[i] > dlim
      |=> !dark_q[i]) else $error("dark release missed");
    hold_res_a: assert property (!vld_q[i] && den_q[i] &&
      oen_q[i] && !cfg_we[i] |=> $stable(dark_q[i]) &&
      $stable(office_q[i])) else $error("result moved");
    office_lvl_a: assert property (office_q[i] && !dark_q[i]
      |-> level[i] == ALC_OFFICE) else $error("office level wrong");

    forced_c: cover property (fstart[i] ##2 !force_q[i]);
    dark_c:   cover property (vld_q[i] ##1 dark_q[i]);
    office_c: cover property (vld_q[i] ##1 office_q[i] && !dark_q[i]);
  end

endmodule

/* dv/alc_sensor_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Light sensor pair: turns a wanted light level into a live code
// ------------------------------------------------------------------
module alc_sensor_model
  import alc_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic [ALC_CONV_W-1:0] want_one,
  input  wire logic [ALC_CONV_W-1:0] want_two,
  output logic      [ALC_CONV_W-1:0] first_light_input,
  output logic      [ALC_CONV_W-1:0] second_light_input
);
  // Codes settle one edge after the light changes, like a real front end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      first_light_input  <= '0;
      second_light_input <= '0;
    end else begin
      first_light_input  <= want_one;
      second_light_input <= want_two;
    end
  end
endmodule

/* dv/test_ambient_light_level_compare.sv */
`timescale 1ns/1ps
module test_ambient_light_level_compare
  import alc_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int CONV = 20;    // Short conversion interval
  localparam int WDOG = 20000; // Hang limit in cycles
  logic                  mclk, rst_n, backlight_on, sinks_running;
  alc_reg_req_t          req;
  logic [7:0]            reg_rd_data, dthr, dhys, othr, ohys, rd, d;
  logic [ALC_CONV_W-1:0] in_one, in_two, want_one, want_two;
  logic [ALC_CONV_W-1:0] cv_one, cv_two, v;
  logic [ALC_CODE_W-1:0] c1, c2, c3;
  alc_level_t            lv_one, lv_two;
  logic                  ost [2];   // Expected office results
  logic                  dst [2];   // Expected dark results
  logic [6:0]            led [3];   // Expected sink codes
  integer                seed, n_mismatch, checks_done, k;

  alc_compare #(.CONV_CYCLES(CONV)) u_alc_compare (
    .mclk(mclk), .rst_n(rst_n), .reg_req(req), .reg_rd_data(reg_rd_data),
    .first_light_input(in_one), .second_light_input(in_two),
    .backlight_on(backlight_on), .sinks_running(sinks_running),
    .dark_threshold_code(dthr), .dark_hysteresis_code(dhys),
    .led1_current_code(c1), .led2_current_code(c2),
    .led3_current_code(c3), .level_one(lv_one), .level_two(lv_two),
    .conv_value_one(cv_one), .conv_value_two(cv_two));

  alc_sensor_model u_alc_sensor_model (
    .mclk(mclk), .rst_n(rst_n), .want_one(want_one), .want_two(want_two),
    .first_light_input(in_one), .second_light_input(in_two));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One byte write, idle cycle before the next access
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] dat);
    @(negedge mclk);
    req.addr = a;
    req.wdata = dat;
    req.wr = 1'b1;
    @(negedge mclk);
    req.wr = 1'b0;
  endtask

  // One byte read, data taken a cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] dat);
    @(negedge mclk);
    req.addr = a;
    req.rd = 1'b1;
    @(negedge mclk);
    req.rd = 1'b0;
    dat = reg_rd_data;
  endtask

  // Trip with hysteresis; a disabled comparator reads zero
  function automatic logic trip(input logic prev, input logic en,
    input logic [12:0] x, input logic [7:0] thr, input logic [7:0] hys);
    if (!en) return 1'b0;
    if (x < 13'(thr)) return 1'b1;
    if (x > 13'(thr) + 13'(hys)) return 1'b0;
    return prev;
  endfunction

  // Level chosen from the two results, dark first
  function automatic logic [1:0] lvl(input logic dk, input logic of);
    return {dk, ~dk & of};
  endfunction

  // Forced conversion on sensor s; pend means the request already waits
  task automatic forced(input int s, input logic [12:0] x,
    input logic [7:0] cfg, input logic pend);
    logic [7:0] a;
    int         n;
    a = (s == 1) ? ALC_ADDR_CFG2 : ALC_ADDR_CFG1;
    if (s == 1) want_two = x;
    else want_one = x;
    if (pend) sinks_running = 1'b1;
    else reg_wr(a, cfg | 8'h10);
    n = 0;
    rd = 8'h10;
    while (rd[4] !== 1'b0 && n < 10) begin
      reg_rd(a, rd);
      n++;
    end
    ost[s] = trip(ost[s], cfg[0], x >> 3, othr, ohys);
    dst[s] = trip(dst[s], cfg[1], x, dthr, dhys);
    check(rd, {cfg[7:5], 1'b0, dst[s], ost[s], cfg[1:0]});
    check((s == 1) ? cv_two : cv_one, x);
    check((s == 1) ? lv_two : lv_one, lvl(dst[s], ost[s]));
  endtask

  // Verdict and end of run
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial begin
    repeat (WDOG) @(posedge mclk);
    n_mismatch++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 80;
    n_mismatch = 0;
    checks_done = 0;
    req = '0;
    rst_n = 1'b0;
    {backlight_on, sinks_running} = 2'b01;
    {dthr, dhys, othr, ohys} = '0;
    {want_one, want_two} = '0;
    ost = '{1'b0, 1'b0};
    dst = '{1'b0, 1'b0};
    repeat (5) @(negedge mclk);
    rst_n = 1'b1;
    // Every register starts cleared, a hole reads zero
    for (k = 8'h18; k <= 8'h1e; k++) begin
      reg_rd(8'(k), rd);
      check(rd, ALC_REG_RST);
    end
    reg_rd(8'h17, rd);
    check(rd, ALC_UNMAPPED);
    check(lv_one, ALC_DAYLIGHT);
    // Sink codes: bit 7 reserved, all-ones code last
    for (k = 0; k < 3; k++) begin
      d = (k == 2) ? 8'hff : 8'($random(seed));
      led[k] = d[6:0];
      reg_wr(ALC_ADDR_LED3 + 8'(k), d);
      reg_rd(ALC_ADDR_LED3 + 8'(k), rd);
      check(rd, {1'b0, led[k]});
    end
    check({c3, c2, c1}, {led[0], led[1], led[2]});
    // Random forced conversions with corner light levels
    for (k = 0; k < 40; k++) begin
      othr = 8'({$random(seed)} % 251);
      // software keeps threshold plus hysteresis at most 250
      ohys = 8'({$random(seed)} % (251 - othr));
      reg_wr(ALC_ADDR_OTHR, othr);
      reg_wr(ALC_ADDR_OHYS, ohys);
      reg_rd(ALC_ADDR_OTHR, rd);
      check(rd, othr);
      reg_rd(ALC_ADDR_OHYS, rd);
      check(rd, ohys);
      dthr = 8'($random(seed));
      dhys = 8'($random(seed));
      v = 13'({$random(seed)} % 2200);
      if (k % 4 == 0) v = 13'(othr) << 3;
      if (k % 4 == 1) v = (13'(othr) + 13'(ohys) + 13'd1) << 3;
      if (k % 4 == 2 && dthr != 0) v = 13'(dthr) - 13'd1;
      forced(k % 2, v, 8'($random(seed)), 1'b0);
    end
    // Request pends while sinks are idle, completes once they run
    sinks_running = 1'b0;
    want_one = 13'h0a5;
    reg_wr(ALC_ADDR_CFG1, 8'h13);
    repeat (6) @(negedge mclk);
    reg_rd(ALC_ADDR_CFG1, rd);
    check(rd[4], 1'b1);
    forced(0, 13'h0a5, 8'h03, 1'b1);
    // Request with backlight on is dropped, no conversion
    reg_wr(ALC_ADDR_CFG1, 8'h00);
    backlight_on = 1'b1;
    want_one = 13'h1555;
    reg_wr(ALC_ADDR_CFG1, 8'h10);
    repeat (4) @(negedge mclk);
    reg_rd(ALC_ADDR_CFG1, rd);
    check(rd, 8'h00);
    check(cv_one, 13'h0a5);
    // Periodic smoothing: two samples on one, single sample on two
    reg_wr(ALC_ADDR_OTHR, 8'd100);
    reg_wr(ALC_ADDR_OHYS, 8'd20);
    dthr = 8'd200;
    want_one = 13'd799;
    want_two = 13'd150;
    reg_wr(ALC_ADDR_CFG1, 8'h21);
    reg_wr(ALC_ADDR_CFG2, 8'h02);
    repeat (3 * CONV + 10) @(negedge mclk);
    check(cv_one, 13'd799);
    check(cv_two, 13'd150);
    check(lv_one, ALC_OFFICE);
    check(lv_two, ALC_DARK);
    reg_rd(ALC_ADDR_CFG2, rd);
    check(rd, 8'h0a);
    conclude();
  end
endmodule
